// *** core/fpi_ctrl.v ***
// seven source fixed priority interrupt logic with idle/power-down control
// assumes the core pulses acknowledge on vector fetch and return at the
// end of service, and that pins ext_request_* are asynchronous, active low
`timescale 1ns/100ps
`default_nettype none
`include "fpi_defs.vh"

// Summary of operation
// (RULE_01) seven sources share one level, no priority register, no nesting.
// (RULE_02) grant order is ext0, timer0, ext1, pwm, watchdog, serial, adc.
// (RULE_03) reset starts at 000, ext0 at 003, timer0 at 00B, ext1 at 013.
// (RULE_04) watchdog vector is 001B, serial 0023, adc 002B, pwm 0033.
// (RULE_05) a request goes out only when its enable and global enable are set.
// (RULE_06) idle halts core, adc and pwm; timer0, serial, watchdog, irqs run.
// (RULE_07) the idle request completes its instruction, then idle begins.
// (RULE_08) idle freezes core state, data memory and special registers.
// (RULE_09) an enabled interrupt ends idle and the core enters its routine.
// (RULE_10) reset in idle restarts the core as a power-on reset does.
// (RULE_11) power-down follows its instruction and stops the oscillator.
// (RULE_12) power-down is left only by hardware reset, never by an interrupt.
// (RULE_13) idle and power-down request bits sit in power mode control.
// (RULE_14) pins keep their latched data in idle and power-down, except pwm.
// (RULE_15) the outside holds reset high two machine cycles, clock running.
// (RULE_16) the pwm output is driven high throughout idle and power-down.
// (RULE_17) a request during service waits for the return before vectoring.
module fpi_ctrl
#(
  parameter NUM_SRC = `FPI_NUM_SRC
)
(
  input  wire                clock,
  input  wire                sys_rst,
  input  wire                ext_request_0,
  input  wire                ext_request_1,
  input  wire                timer0_overflow_flag,
  input  wire                pwm_request,
  input  wire                watchdog_request,
  input  wire                serial_bus_request,
  input  wire                adc_request,
  input  wire [NUM_SRC-1:0]  irq_enable,
  input  wire                global_irq_enable,
  input  wire                pmc_write,
  input  wire [1:0]          pmc_wdata,
  input  wire                irq_ack,
  input  wire                irq_return,
  input  wire                pwm_level,
  output reg                 irq_req,
  output reg  [15:0]         irq_vector,
  output reg  [NUM_SRC-1:0]  irq_pending,
  output reg                 in_service,
  output reg  [1:0]          power_mode_control,
  output reg                 core_halt,
  output reg                 adc_pwm_halt,
  output reg                 osc_stop,
  output reg                 pwm_pin
);

  localparam MODE_RUN   = `FPI_MODE_RUN;
  localparam MODE_IDLE  = `FPI_MODE_IDLE;
  localparam MODE_PDOWN = `FPI_MODE_PDOWN;

  // ----------------------------------------------------------------
  // source index to program address
  // ----------------------------------------------------------------
  function [15:0] fpi_vec;
    input [2:0] idx;
    begin
      case (idx)
        `FPI_SRC_EXT0: fpi_vec = `FPI_VEC_EXT0;                     // RULE_03
        `FPI_SRC_TMR0: fpi_vec = `FPI_VEC_TMR0;                     // RULE_03
        `FPI_SRC_EXT1: fpi_vec = `FPI_VEC_EXT1;                     // RULE_03
        `FPI_SRC_PWM:  fpi_vec = `FPI_VEC_PWM;                      // RULE_04
        `FPI_SRC_WDT:  fpi_vec = `FPI_VEC_WDT;                      // RULE_04
        `FPI_SRC_SER:  fpi_vec = `FPI_VEC_SER;                      // RULE_04
        `FPI_SRC_ADC:  fpi_vec = `FPI_VEC_ADC;                      // RULE_04
        default:       fpi_vec = `FPI_VEC_RESET;
      endcase
    end
  endfunction

  wire               ext0_level;
  wire               ext1_level;
  reg                ext0_prev_reg;
  reg                ext1_prev_reg;
  wire [NUM_SRC-1:0] src_event;
  wire [NUM_SRC-1:0] forwardable;
  reg  [2:0]         win_idx;
  reg                win_any;
  reg  [1:0]         mode_reg;
  reg  [1:0]         mode_next;
  reg  [2:0]         svc_idx_reg;
  integer            i;

  // ----------------------------------------------------------------
  // external pins
  // ----------------------------------------------------------------
  fpi_sync u_sync_ext0
  (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .pin_in    (ext_request_0),
    .level_out (ext0_level)
  );

  fpi_sync u_sync_ext1
  (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .pin_in    (ext_request_1),
    .level_out (ext1_level)
  );

  // falling edge of an active low pin makes one request
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ext0_prev_reg <= 1'b1;
      ext1_prev_reg <= 1'b1;
    end
    else
    begin
      ext0_prev_reg <= ext0_level;
      ext1_prev_reg <= ext1_level;
    end
  end

  // ----------------------------------------------------------------
  // source events in priority order
  // ----------------------------------------------------------------
  assign src_event[`FPI_SRC_EXT0] = ext0_prev_reg & ~ext0_level;
  assign src_event[`FPI_SRC_TMR0] = timer0_overflow_flag;
  assign src_event[`FPI_SRC_EXT1] = ext1_prev_reg & ~ext1_level;
  assign src_event[`FPI_SRC_PWM]  = pwm_request;
  assign src_event[`FPI_SRC_WDT]  = watchdog_request;
  assign src_event[`FPI_SRC_SER]  = serial_bus_request;
  assign src_event[`FPI_SRC_ADC]  = adc_request;

  // masked requests stay pending; only the forwarded set is gated
  assign forwardable = irq_pending & irq_enable &
                       {NUM_SRC{global_irq_enable}};              // RULE_05

  // ----------------------------------------------------------------
  // fixed priority pick, lowest index wins
  // ----------------------------------------------------------------
  // scan downward so the last hit is the highest priority
  always @*
  begin
    win_idx = 3'd0;
    win_any = 1'b0;
    for (i = NUM_SRC - 1; i >= 0; i = i - 1)
    begin
      if (forwardable[i])
      begin
        win_idx = i[2:0];                                         // RULE_02
        win_any = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pending flags, one per source
  // ----------------------------------------------------------------
  // a fresh event in the clearing cycle wins so no request is lost
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g = g + 1)
    begin : g_pend
      always @(posedge clock or posedge sys_rst)
      begin
        if (sys_rst)
          irq_pending[g] <= 1'b0;
        else if (src_event[g])
          irq_pending[g] <= 1'b1;                                 // RULE_01
        else if (irq_ack && irq_req && win_idx == g)
          irq_pending[g] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // mode control
  // ----------------------------------------------------------------
  // the write strobe marks the completing instruction; mode starts next
  always @*
  begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_RUN:
      begin
        if (pmc_write && pmc_wdata[`FPI_PMC_PDOWN])
          mode_next = MODE_PDOWN;                                 // RULE_11
        else if (pmc_write && pmc_wdata[`FPI_PMC_IDLE])
          mode_next = MODE_IDLE;                                  // RULE_07
      end
      MODE_IDLE:
      begin
        if (win_any && !in_service)
          mode_next = MODE_RUN;                                   // RULE_09
      end
      MODE_PDOWN:
        mode_next = MODE_PDOWN;                                   // RULE_12
      default:
        mode_next = MODE_RUN;
    endcase
  end

  // reset from any mode returns to run at address zero
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      mode_reg <= MODE_RUN;                                       // RULE_10
    else
      mode_reg <= mode_next;
  end

  // ----------------------------------------------------------------
  // power mode control register
  // ----------------------------------------------------------------
  // bits clear when the mode they asked for ends
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      power_mode_control <= `FPI_PMC_RESET;
    else if (mode_reg == MODE_RUN && pmc_write)
      power_mode_control <= pmc_wdata;                            // RULE_13
    else if (mode_reg == MODE_IDLE && mode_next == MODE_RUN)
      power_mode_control[`FPI_PMC_IDLE] <= 1'b0;
  end

  // ----------------------------------------------------------------
  // halts and pins
  // ----------------------------------------------------------------
  // halting the core freezes its registers and memory in place
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      core_halt    <= 1'b0;
      adc_pwm_halt <= 1'b0;
      osc_stop     <= 1'b0;
      pwm_pin      <= 1'b1;
    end
    else
    begin
      core_halt    <= (mode_next != MODE_RUN);                    // RULE_08
      adc_pwm_halt <= (mode_next != MODE_RUN);                    // RULE_06
      osc_stop     <= (mode_next == MODE_PDOWN);                  // RULE_11
      // other port pins keep their latches; only pwm is overridden
      if (mode_next != MODE_RUN)
        pwm_pin <= 1'b1;                                          // RULE_16
      else
        pwm_pin <= pwm_level;                                     // RULE_14
    end
  end

  // ----------------------------------------------------------------
  // request to the core and service tracking
  // ----------------------------------------------------------------
  // one level only: nothing vectors while a routine is in service
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_req     <= 1'b0;
      irq_vector  <= `FPI_VEC_RESET;                              // RULE_03
      in_service  <= 1'b0;
      svc_idx_reg <= 3'd0;
    end
    else
    begin
      if (irq_ack && irq_req)
      begin
        in_service  <= 1'b1;                                      // RULE_01
        svc_idx_reg <= win_idx;
        irq_req     <= 1'b0;
      end
      else if (irq_return)
      begin
        in_service <= 1'b0;                                       // RULE_17
        irq_req    <= 1'b0;
      end
      else if (!in_service && win_any && mode_next != MODE_PDOWN)
      begin
        irq_req    <= 1'b1;                                       // RULE_05
        irq_vector <= fpi_vec(win_idx);                           // RULE_02
      end
      else
        irq_req <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** core/fpi_defs.vh ***
// constants for the fixed priority interrupt and power mode block
// assumes inclusion by bare name from files under core/
`ifndef FPI_DEFS_VH
`define FPI_DEFS_VH

// ----------------------------------------------------------------
// source count and source index in priority order, 0 is highest
// ----------------------------------------------------------------
`define FPI_NUM_SRC      7
`define FPI_SRC_EXT0     0
`define FPI_SRC_TMR0     1
`define FPI_SRC_EXT1     2
`define FPI_SRC_PWM      3
`define FPI_SRC_WDT      4
`define FPI_SRC_SER      5
`define FPI_SRC_ADC      6

// ----------------------------------------------------------------
// program memory start addresses
// ----------------------------------------------------------------
`define FPI_VEC_RESET    16'h0000
`define FPI_VEC_EXT0     16'h0003
`define FPI_VEC_TMR0     16'h000B
`define FPI_VEC_EXT1     16'h0013
`define FPI_VEC_WDT      16'h001B
`define FPI_VEC_SER      16'h0023
`define FPI_VEC_ADC      16'h002B
`define FPI_VEC_PWM      16'h0033

// ----------------------------------------------------------------
// power mode control field positions and reset value
// ----------------------------------------------------------------
`define FPI_PMC_IDLE     0
`define FPI_PMC_PDOWN    1
`define FPI_PMC_RESET    2'h0

// ----------------------------------------------------------------
// mode encodings
// ----------------------------------------------------------------
`define FPI_MODE_RUN     2'h0
`define FPI_MODE_IDLE    2'h1
`define FPI_MODE_PDOWN   2'h2

`endif

// *** core/fpi_sync.v ***
// three flip-flop synchroniser with agreement filter for pin inputs
// assumes one clock; the pin may change at any time
`timescale 1ns/100ps
`default_nettype none

module fpi_sync
(
  input  wire clock,
  input  wire sys_rst,
  input  wire pin_in,
  output reg  level_out
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // ----------------------------------------------------------------
  // capture chain
  // ----------------------------------------------------------------
  // s1 feeds only s2 to keep metastability out of the filter
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      s3_reg    <= 1'b1;
      level_out <= 1'b1;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level_out <= s3_reg;      // change counts once two stages agree
    end
  end

endmodule

`default_nettype wire

// *** tb/fpi_props.sv ***
// checker for the interrupt and power mode block, bound to fpi_ctrl
// assumes one clock and sys_rst asynchronous, active high
`timescale 1ns/100ps
`default_nettype none
`include "fpi_defs.vh"

module fpi_props
#(
  parameter NUM_SRC = 7
)
(
  input wire logic               clock,
  input wire logic               sys_rst,
  input wire logic [NUM_SRC-1:0] irq_enable,
  input wire logic               global_irq_enable,
  input wire logic               pmc_write,
  input wire logic [1:0]         pmc_wdata,
  input wire logic               irq_ack,
  input wire logic               irq_return,
  input wire logic               irq_req,
  input wire logic [15:0]        irq_vector,
  input wire logic [NUM_SRC-1:0] irq_pending,
  input wire logic               in_service,
  input wire logic [1:0]         power_mode_control,
  input wire logic               core_halt,
  input wire logic               adc_pwm_halt,
  input wire logic               osc_stop,
  input wire logic               pwm_pin
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lowest index wins, so the table reads in priority order
  function automatic [15:0] fpi_top(input [NUM_SRC-1:0] p);
    begin
      if (p[0]) fpi_top = `FPI_VEC_EXT0;
      else if (p[1]) fpi_top = `FPI_VEC_TMR0;
      else if (p[2]) fpi_top = `FPI_VEC_EXT1;
      else if (p[3]) fpi_top = `FPI_VEC_PWM;
      else if (p[4]) fpi_top = `FPI_VEC_WDT;
      else if (p[5]) fpi_top = `FPI_VEC_SER;
      else fpi_top = `FPI_VEC_ADC;
    end
  endfunction
  // a request the core may be offered right now
  wire fwd;
  assign fwd = (|(irq_pending & irq_enable)) && global_irq_enable
               && !in_service && !osc_stop;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_vector_pick: assert property (
    irq_req && $stable(irq_pending & irq_enable)
    |-> irq_vector == fpi_top(irq_pending & irq_enable))
    else $error("vector is not that of the highest pending source");
  a_no_nesting: assert property (in_service |-> !irq_req)
    else $error("request offered during service");
  a_masked_quiet: assert property (
    !global_irq_enable [*2] |-> !irq_req)
    else $error("request offered with global enable low");
  a_forward_next: assert property (
    fwd && !irq_req && !pmc_write |=> irq_req)
    else $error("enabled pending not offered one cycle later");
  a_ack_taken: assert property (
    irq_req && irq_ack |=> in_service && !irq_req)
    else $error("acknowledge did not start service");
  a_return_ends: assert property (
    in_service && irq_return |=> !in_service)
    else $error("return did not end service");
  a_idle_entry: assert property (
    pmc_write && pmc_wdata == 2'h1 && !core_halt |=> core_halt
    && adc_pwm_halt && !osc_stop && pwm_pin && power_mode_control[0])
    else $error("idle not entered after its write");
  a_pdown_entry: assert property (
    pmc_write && pmc_wdata[1] && !core_halt
    |=> osc_stop && core_halt && power_mode_control[1])
    else $error("power-down not entered after its write");
  a_pdown_holds: assert property (
    osc_stop |=> osc_stop && core_halt && !irq_req)
    else $error("power-down left without reset");
  a_pin_high: assert property (core_halt |-> pwm_pin)
    else $error("pwm pin low while halted");
  a_idle_wake: assert property (
    core_halt && fwd && !irq_req |=> !core_halt && irq_req)
    else $error("enabled interrupt did not end idle");

  c_service: cover property (irq_req && irq_ack);
  c_idle: cover property (core_halt && !osc_stop && fwd);
  c_pdown: cover property ($rose(osc_stop));
endmodule

bind fpi_ctrl fpi_props #(.NUM_SRC(NUM_SRC)) props_u (.clock, .sys_rst,
  .irq_enable, .global_irq_enable, .pmc_write, .pmc_wdata, .irq_ack,
  .irq_return, .irq_req, .irq_vector, .irq_pending, .in_service,
  .power_mode_control, .core_halt, .adc_pwm_halt, .osc_stop, .pwm_pin);
`default_nettype wire

// *** tb/fpi_core_model.sv ***
// core model: takes a vector, runs a routine, then returns
// assumes irq_req stands until the acknowledge is sampled
`timescale 1ns/100ps
`default_nettype none

module fpi_core_model
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        auto_ack,
  input  wire logic [3:0]  ack_wait,
  input  wire logic [3:0]  service_len,
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  output var  logic        irq_ack,
  output var  logic        irq_return,
  output var  logic [15:0] last_vector,
  output var  logic [7:0]  n_serviced
);
  logic       busy_reg;
  logic [3:0] cnt_reg;
  logic [3:0] wait_reg;
  // one routine at a time; slow acks come from ack_wait
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      {irq_ack, irq_return, busy_reg} <= 3'h0;
      {cnt_reg, wait_reg} <= 8'h00;
      last_vector <= 16'h0000;
      n_serviced <= 8'h00;
    end
    else
    begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      // vector is taken at the edge the design samples the ack
      if (irq_ack)
        last_vector <= irq_vector;
      if (irq_ack)
        n_serviced <= n_serviced + 8'h01;
      if (busy_reg && cnt_reg == 4'h0)
      begin
        irq_return <= 1'b1;
        busy_reg <= 1'b0;
      end
      else if (busy_reg)
        cnt_reg <= cnt_reg - 4'h1;
      else if (irq_req && auto_ack && wait_reg == ack_wait)
      begin
        irq_ack <= 1'b1;
        busy_reg <= 1'b1;
        cnt_reg <= service_len;
        wait_reg <= 4'h0;
      end
      else if (irq_req && auto_ack)
        wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for fpi_ctrl with a core model on its far side
// assumes fpi_defs.vh is on the include path
`timescale 1ns/100ps
`default_nettype none
`include "fpi_defs.vh"

module testbench;
  logic        clock, sys_rst, ext_request_0, ext_request_1;
  logic        timer0_overflow_flag, pwm_request, watchdog_request;
  logic        serial_bus_request, adc_request, global_irq_enable;
  logic        pmc_write, irq_ack, irq_return, pwm_level, irq_req;
  logic        in_service, core_halt, adc_pwm_halt, osc_stop, pwm_pin;
  logic        auto_ack;
  logic [1:0]  pmc_wdata, power_mode_control;
  logic [3:0]  ack_wait, service_len;
  logic [6:0]  irq_enable, irq_pending;
  logic [7:0]  n_serviced;
  logic [15:0] irq_vector, last_vector;
  logic [15:0] exp_vec [0:6];
  int          mismatches, n_tests, i;

  fpi_ctrl #(.NUM_SRC(7)) dut_u (.clock, .sys_rst, .ext_request_0,
    .ext_request_1, .timer0_overflow_flag, .pwm_request, .watchdog_request,
    .serial_bus_request, .adc_request, .irq_enable, .global_irq_enable,
    .pmc_write, .pmc_wdata, .irq_ack, .irq_return, .pwm_level, .irq_req,
    .irq_vector, .irq_pending, .in_service, .power_mode_control,
    .core_halt, .adc_pwm_halt, .osc_stop, .pwm_pin);
  fpi_core_model core_u (.clock, .sys_rst, .auto_ack, .ack_wait,
    .service_len, .irq_req, .irq_vector, .irq_ack, .irq_return,
    .last_vector, .n_serviced);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: vector %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bits(input logic [6:0] got, input logic [6:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: flags %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // ext pins are held low long enough to pass the input filter
  task automatic fire(input logic [6:0] m);
    @(posedge clock);
    // bit order follows source priority; ext pins are active low
    {adc_request, serial_bus_request, watchdog_request, pwm_request,
     ext_request_1, timer0_overflow_flag, ext_request_0} <= m ^ 7'h05;
    @(posedge clock);
    {timer0_overflow_flag, pwm_request, watchdog_request} <= 3'h0;
    {serial_bus_request, adc_request} <= 2'h0;
    repeat (6) @(posedge clock);
    {ext_request_0, ext_request_1} <= 2'h3;
    #1;
  endtask
  task automatic pmc(input logic [1:0] d);
    @(posedge clock);
    pmc_write <= 1'b1;
    pmc_wdata <= d;
    @(posedge clock);
    pmc_write <= 1'b0;
    #1;
  endtask
  task automatic hw_reset;
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
  endtask
  task automatic wait_serv(input logic [7:0] n);
    for (int k = 0; k < 200 && n_serviced !== n; k++)
      tick(1);
    if (n_serviced !== n)
    begin
      mismatches++;
      final_report;
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // a hang anywhere still ends in the closing report
  initial
  begin
    #500000;
    mismatches++;
    final_report;
  end
  initial
  begin
    {sys_rst, ext_request_0, ext_request_1} = 3'h7;
    {timer0_overflow_flag, pwm_request, watchdog_request} = 3'h0;
    {serial_bus_request, adc_request, global_irq_enable} = 3'h0;
    {pmc_write, pmc_wdata, pwm_level, auto_ack} = 5'h00;
    {ack_wait, service_len} = 8'h02;
    irq_enable = 7'h3F;
    {mismatches, n_tests} = 0;
    exp_vec = '{`FPI_VEC_EXT0, `FPI_VEC_TMR0, `FPI_VEC_EXT1, `FPI_VEC_PWM,
                `FPI_VEC_WDT, `FPI_VEC_SER, `FPI_VEC_ADC};
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    tick(1);
    chk_vec(irq_vector, `FPI_VEC_RESET);
    chk_bits({pwm_pin, irq_pending[5:0]}, 7'h00);
    // masked source stays pending until its enable is set
    @(posedge clock);
    {global_irq_enable, auto_ack} <= 2'h3;
    fire(7'h40);
    tick(4);
    chk_bits({irq_req, irq_pending[5:0]}, 7'h00);
    chk_bits(irq_pending, 7'h40);
    @(posedge clock);
    irq_enable <= 7'h7F;
    wait_serv(8'h01);
    chk_vec(last_vector, `FPI_VEC_ADC);
    // all seven pending at once, granted one at a time
    @(posedge clock);
    global_irq_enable <= 1'b0;
    fire(7'h7F);
    tick(4);
    chk_bits(irq_pending, 7'h7F);
    chk_bits({6'h00, irq_req}, 7'h00);
    @(posedge clock);
    global_irq_enable <= 1'b1;
    for (i = 0; i < 7; i++)
    begin
      wait_serv(8'(i + 2));
      chk_vec(last_vector, exp_vec[i]);
      @(posedge clock);
      ack_wait <= 4'(i);
    end
    // idle, then woken by an enabled timer request
    tick(8);
    pmc(2'h1);
    chk_bits({1'b0, pwm_pin, core_halt, adc_pwm_halt, osc_stop,
              power_mode_control}, 7'h39);
    fire(7'h02);
    wait_serv(8'h09);
    chk_vec(last_vector, `FPI_VEC_TMR0);
    chk_bits({4'h0, pwm_pin, core_halt, power_mode_control[0]},
             7'h00);
    // in run the pin must follow the generator, not sit at a constant
    @(posedge clock);
    pwm_level <= 1'b1;
    tick(2);
    chk_bits({6'h00, pwm_pin}, 7'h01);
    // reset in idle restarts as from power-on
    tick(12);
    pmc(2'h1);
    hw_reset;
    chk_vec(irq_vector, `FPI_VEC_RESET);
    chk_bits({4'h0, core_halt, power_mode_control}, 7'h00);
    // power-down ignores interrupts and later writes
    pmc(2'h3);
    chk_bits({4'h0, osc_stop, core_halt, power_mode_control[1]},
             7'h07);
    fire(7'h01);
    pmc(2'h1);
    tick(20);
    chk_bits({4'h0, osc_stop, core_halt, irq_req}, 7'h06);
    chk_bits(n_serviced[6:0], 7'h00);
    hw_reset;
    chk_bits({5'h00, osc_stop, core_halt}, 7'h00);
    final_report;
  end
endmodule
`default_nettype wire
